// ---- core/tagfe_i2c_front_end.sv ----
// Serial-bus slave front end with status and harvest outputs of the tag
`timescale 1ns/1ps
// Contract
// - Bits sampled and launched on master clock
// - Data line is open drain only
// - Select byte: type, area, ones, direction
// - Bytes travel most significant bit first
// - Address high byte then low byte
// - Ignore bus until power good, then reset
// - Stop answering when power drops
// - Stop gives standby unless write running
// - Status pin shows write or command activity
// - Status pin driven only with supply power
// - Harvest output only when enabled and field
// - Acknowledge in ninth bit after bytes
// - Write mode: low during RF write
// - Command mode: low during RF command
module tagfe_i2c_front_end #(
  parameter logic [3:0]  DEV_TYPE     = 4'h5,  // Arbitrary value
  parameter int unsigned WRITE_CYCLES = tagfe_pkg::WRITE_CYCLE_CYC
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire tagfe_pkg::tagfe_avs_req_t i_avs,
  output tagfe_pkg::tagfe_avs_rsp_t     o_avs,
  input  wire logic                     i_scl,
  input  wire logic                     i_sda_i,
  output logic                          o_sda_o,
  output logic                          o_sda_oe,
  input  wire logic                     i_vcc_por_ok,
  input  wire logic                     i_rf_write_busy,
  input  wire logic                     i_rf_cmd_busy,
  input  wire logic                     i_rf_field_ok,
  output logic                          o_rf_activity_out_o,
  output logic                          o_rf_activity_out_oe,
  output logic                          o_harvest_on
);
  import tagfe_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [5:0] sync_q;
  logic       scl_s;
  logic       sda_s;
  logic       por_s;
  logic       rfw_s;
  logic       rfc_s;
  logic       field_s;

  tagfe_sync #(
    .W (6)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_scl, i_sda_i, i_vcc_por_ok, i_rf_write_busy, i_rf_cmd_busy, i_rf_field_ok}),
    .o_q     (sync_q)
  );

  assign {scl_s, sda_s, por_s, rfw_s, rfc_s, field_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // State and decoded events
  tagfe_state_t r;
  tagfe_state_t n;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_ev;
  logic         stop_ev;
  logic         byte_done;
  logic         sel_ok;
  logic         bus_live;
  logic         standby;
  logic [31:0]  rd_mux;

  assign scl_rise  = scl_s & ~r.scl_q;
  assign scl_fall  = ~scl_s & r.scl_q;
  assign start_ev  = scl_s & r.scl_q & r.sda_q & ~sda_s;
  assign stop_ev   = scl_s & r.scl_q & ~r.sda_q & sda_s;
  assign byte_done = scl_fall & ~r.in_ack & (r.cnt == BITS_PER_BYTE);
  assign sel_ok    = (r.shift[DSEL_TYPE_MSB:DSEL_TYPE_LSB] == DEV_TYPE)
                   & (r.shift[2:1] == DSEL_FIXED) & ~r.wbusy;
  assign bus_live  = por_s & r.por_q;
  assign standby   = (r.fsm == ST_STANDBY) & ~r.wbusy;

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_avs.address)
      REG_CTRL: begin
        rd_mux[CTRL_MODE_BIT] = r.ctrl_mode;
        rd_mux[CTRL_HARV_BIT] = r.ctrl_harv;
      end
      REG_TXDATA: rd_mux[7:0] = r.txdata;
      REG_STATUS: begin
        rd_mux[STAT_STANDBY_BIT] = standby;
        rd_mux[STAT_WBUSY_BIT]   = r.wbusy;
        rd_mux[STAT_SEL_BIT]     = (r.fsm != ST_STANDBY) && (r.fsm != ST_IGNORE);
        rd_mux[STAT_AREA_BIT]    = r.area;
        rd_mux[STAT_POR_BIT]     = r.por_q;
      end
      REG_ADDR:   rd_mux[15:0] = r.addr;
      REG_RXDATA: rd_mux[7:0]  = r.rxdata;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n       = r;
    n.scl_q = scl_s;
    n.sda_q = sda_s;
    n.por_q = por_s;
    n.sda_o = 1'b0;
    n.rf_o  = 1'b0;
    // Bus slave: one wait cycle, write lands when waitrequest is low
    n.avs_wait = 1'b1;
    if ((i_avs.read || i_avs.write) && r.avs_wait) begin
      n.avs_wait  = 1'b0;
      n.avs_rdata = i_avs.read ? rd_mux : 32'h0000_0000;
    end
    if (i_avs.write && !r.avs_wait && i_avs.byteenable[0]) begin
      case (i_avs.address)
        REG_CTRL: begin
          n.ctrl_mode = i_avs.writedata[CTRL_MODE_BIT];
          n.ctrl_harv = i_avs.writedata[CTRL_HARV_BIT];
        end
        REG_TXDATA: n.txdata = i_avs.writedata[7:0];
        default: n.txdata = r.txdata;
      endcase
    end
    // Internal write cycle timer
    if (r.wbusy) begin
      if (r.wcnt == '0) begin
        n.wbusy = 1'b0;
      end else begin
        n.wcnt = r.wcnt - 1'b1;
      end
    end
    // Status and harvest outputs
    n.rf_oe      = por_s & (r.ctrl_mode ? rfc_s : rfw_s);
    n.harvest_on = r.ctrl_harv & field_s;
    // Serial protocol engine
    if (!bus_live) begin
      n.fsm    = ST_STANDBY;
      n.sda_oe = 1'b0;
      n.cnt    = 4'h0;
      n.in_ack = 1'b0;
      n.wrote  = 1'b0;
      n.wbusy  = 1'b0;
    end else if (start_ev) begin
      n.fsm    = ST_DEVSEL;
      n.sda_oe = 1'b0;
      n.cnt    = 4'h0;
      n.in_ack = 1'b0;
    end else if (stop_ev) begin
      n.fsm    = ST_STANDBY;
      n.sda_oe = 1'b0;
      n.in_ack = 1'b0;
      n.wrote  = 1'b0;
      if (r.wrote) begin
        n.wbusy = 1'b1;
        n.wcnt  = WCNT_W'(WRITE_CYCLES - 1);
      end
    end else if (scl_rise) begin
      if (!r.in_ack && r.cnt < BITS_PER_BYTE && r.fsm != ST_STANDBY && r.fsm != ST_IGNORE) begin
        n.shift = {r.shift[6:0], sda_s};
        n.cnt   = r.cnt + 4'h1;
      end else if (r.in_ack && r.fsm == ST_RDATA && !r.sda_oe) begin
        n.rd_acked = ~sda_s;
      end
    end else if (scl_fall) begin
      if (byte_done) begin
        n.in_ack = 1'b1;
        case (r.fsm)
          ST_DEVSEL: begin
            if (sel_ok) begin
              n.sda_oe   = 1'b1;
              n.area     = r.shift[DSEL_AREA_BIT];
              n.rd_acked = 1'b1;
              n.fsm      = r.shift[DSEL_RW_BIT] ? ST_RDATA : ST_ADDR_HI;
            end else begin
              n.fsm = ST_IGNORE;
            end
          end
          ST_ADDR_HI: begin
            n.addr[15:8] = r.shift;
            n.sda_oe     = 1'b1;
            n.fsm        = ST_ADDR_LO;
          end
          ST_ADDR_LO: begin
            n.addr[7:0] = r.shift;
            n.sda_oe    = 1'b1;
            n.fsm       = ST_WDATA;
          end
          ST_WDATA: begin
            n.rxdata = r.shift;
            n.wrote  = 1'b1;
            n.addr   = r.addr + 16'h0001;
            n.sda_oe = 1'b1;
          end
          ST_RDATA: begin
            n.sda_oe = 1'b0;
            n.addr   = r.addr + 16'h0001;
          end
          default: n.fsm = ST_IGNORE;
        endcase
      end else if (r.in_ack) begin
        n.in_ack = 1'b0;
        n.cnt    = 4'h0;
        n.sda_oe = 1'b0;
        if (r.fsm == ST_RDATA) begin
          if (r.rd_acked) begin
            n.tx     = r.txdata;
            n.sda_oe = ~r.txdata[7];
          end else begin
            n.fsm = ST_IGNORE;
          end
        end
      end else if (r.fsm == ST_RDATA && r.cnt != 4'h0) begin
        n.tx     = {r.tx[6:0], 1'b0};
        n.sda_oe = ~r.tx[6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r           <= '0;
      r.fsm       <= ST_STANDBY;
      r.avs_wait  <= 1'b1;
      r.ctrl_mode <= CTRL_MODE_RST;
      r.ctrl_harv <= CTRL_HARV_RST;
      r.txdata    <= TXDATA_RST;
    end else begin
      r <= n;
    end
  end

  assign o_avs.waitrequest    = r.avs_wait;
  assign o_avs.readdata       = r.avs_rdata;
  assign o_sda_o              = r.sda_o;
  assign o_sda_oe             = r.sda_oe;
  assign o_rf_activity_out_o  = r.rf_o;
  assign o_rf_activity_out_oe = r.rf_oe;
  assign o_harvest_on         = r.harvest_on;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_sda_edge_only: assert property ($changed(o_sda_oe) |->
    $past(scl_fall || start_ev || stop_ev || !bus_live))
    else $error("Data line changed away from a clock fall");

  a_sda_open_drain: assert property (o_sda_o == 1'b0 && o_rf_activity_out_o == 1'b0)
    else $error("Open-drain output drove high");

  a_select_fields: assert property ($rose(o_sda_oe) && $past(r.fsm == ST_DEVSEL) |->
    $past(r.shift[7:4] == DEV_TYPE && r.shift[2:1] == DSEL_FIXED))
    else $error("Select byte acknowledged with wrong fields");

  a_addr_lo_order: assert property (bus_live && byte_done && r.fsm == ST_ADDR_LO |=>
    r.addr[7:0] == $past(r.shift) && r.fsm == ST_WDATA)
    else $error("Low address byte not stored in order");

  a_addr_hi_order: assert property (bus_live && byte_done && r.fsm == ST_ADDR_HI |=>
    r.addr[15:8] == $past(r.shift) && r.fsm == ST_ADDR_LO)
    else $error("High address byte not stored first");

  a_power_gate: assert property (!por_s |=> ##1 !o_sda_oe && r.fsm == ST_STANDBY)
    else $error("Bus answered without power");

  a_stop_standby: assert property (bus_live && stop_ev |=> r.fsm == ST_STANDBY && !o_sda_oe)
    else $error("Stop did not lead to standby");

  a_status_wip: assert property (por_s && !r.ctrl_mode && rfw_s |=> o_rf_activity_out_oe)
    else $error("Status pin not low during RF write");

  a_status_cmd: assert property (por_s && r.ctrl_mode && rfc_s |=> o_rf_activity_out_oe)
    else $error("Status pin not low during RF command");

  a_status_power: assert property (!por_s |=> !o_rf_activity_out_oe)
    else $error("Status pin driven without supply");

  a_harvest_gate: assert property (o_harvest_on == $past(r.ctrl_harv && field_s))
    else $error("Harvest output wrong for enable and field");

  a_ninth_bit_ack: assert property (bus_live && byte_done && r.fsm == ST_ADDR_LO
    && !start_ev && !stop_ev |=> o_sda_oe)
    else $error("No acknowledge in ninth bit");

  a_read_direction: assert property (bus_live && byte_done && r.fsm == ST_DEVSEL && sel_ok
    && !start_ev && !stop_ev |=> r.fsm == (($past(r.shift[0])) ? ST_RDATA : ST_ADDR_HI))
    else $error("Direction bit decoded wrongly");

  a_avs_one_wait: assert property ((i_avs.read || i_avs.write) && o_avs.waitrequest |=> !o_avs.waitrequest)
    else $error("Bus request not answered after one wait cycle");

  a_avs_wait_pulse: assert property (!o_avs.waitrequest |=> o_avs.waitrequest)
    else $error("Wait request low for more than one cycle");

  a_write_cycle_start: assert property (bus_live && stop_ev && r.wrote |=>
    r.wbusy && r.wcnt == WCNT_W'(WRITE_CYCLES - 1))
    else $error("Stop after data did not start the write cycle");

  a_busy_refuse: assert property (bus_live && byte_done && r.fsm == ST_DEVSEL && r.wbusy |=>
    r.fsm == ST_IGNORE && !o_sda_oe)
    else $error("Select answered during write cycle");

  a_wbusy_countdown: assert property (bus_live && r.wbusy && r.wcnt != '0 && !stop_ev |=>
    r.wbusy && r.wcnt == $past(r.wcnt) - 1'b1)
    else $error("Write cycle timer did not count down");

  a_shift_msb_first: assert property (bus_live && scl_rise && !r.in_ack && r.cnt < BITS_PER_BYTE
    && r.fsm != ST_STANDBY && r.fsm != ST_IGNORE |=> r.shift == {$past(r.shift[6:0]), $past(sda_s)})
    else $error("Serial bit not shifted in most significant first");

  a_read_msb_next: assert property (bus_live && scl_fall && !r.in_ack && r.fsm == ST_RDATA
    && r.cnt != 4'h0 && !byte_done |=> o_sda_oe == !$past(r.tx[6]))
    else $error("Read bit not launched in order");

  a_ack_release: assert property (bus_live && scl_fall && r.in_ack
    && !(r.fsm == ST_RDATA && r.rd_acked) |=> !o_sda_oe)
    else $error("Acknowledge held past the ninth bit");

  a_ignore_silent: assert property (r.fsm == ST_IGNORE |-> !o_sda_oe)
    else $error("Refused transfer drove the data line");

  a_area_capture: assert property ($rose(o_sda_oe) && $past(r.fsm == ST_DEVSEL) |->
    r.area == $past(r.shift[DSEL_AREA_BIT]))
    else $error("Area bit not recorded from select byte");

  a_status_follow: assert property (o_rf_activity_out_oe ==
    $past(por_s && (r.ctrl_mode ? rfc_s : rfw_s)))
    else $error("Status pin does not follow mode and supply");

  a_power_clear: assert property (!bus_live |=> !r.wbusy)
    else $error("Write cycle kept after power loss");

  c_write_byte: cover property (byte_done && r.fsm == ST_WDATA);
  c_read_byte: cover property (byte_done && r.fsm == ST_RDATA);
  c_write_cycle: cover property ($fell(r.wbusy));
  c_status_low: cover property ($rose(o_rf_activity_out_oe));
  c_power_return: cover property ($rose(bus_live));

endmodule : tagfe_i2c_front_end

// ---- core/tagfe_pkg.sv ----
// Package: constants, register map and types of the tag serial front end
package tagfe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned WRITE_CYCLE_NS  = 5_000_000;
  localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_NS / CLK_PERIOD_NS;
  localparam int unsigned WCNT_W          = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TXDATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ADDR   = 8'h0C;
  localparam logic [7:0] REG_RXDATA = 8'h10;

  // Control fields and reset values
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_HARV_BIT = 1;
  localparam logic        CTRL_MODE_RST = 1'h0;
  localparam logic        CTRL_HARV_RST = 1'h0;
  localparam logic [7:0]  TXDATA_RST    = 8'h00;

  // Status fields
  localparam int unsigned STAT_STANDBY_BIT = 0;
  localparam int unsigned STAT_WBUSY_BIT   = 1;
  localparam int unsigned STAT_SEL_BIT     = 2;
  localparam int unsigned STAT_AREA_BIT    = 3;
  localparam int unsigned STAT_POR_BIT     = 4;

  // Device select byte layout
  localparam int unsigned DSEL_TYPE_MSB = 7;
  localparam int unsigned DSEL_TYPE_LSB = 4;
  localparam int unsigned DSEL_AREA_BIT = 3;
  localparam int unsigned DSEL_RW_BIT   = 0;
  localparam logic [1:0]  DSEL_FIXED    = 2'h3;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } tagfe_avs_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } tagfe_avs_rsp_t;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_DEVSEL,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } tagfe_fsm_t;

  typedef struct packed {
    tagfe_fsm_t          fsm;
    logic                scl_q;
    logic                sda_q;
    logic                por_q;
    logic [3:0]          cnt;
    logic                in_ack;
    logic [7:0]          shift;
    logic [7:0]          tx;
    logic [15:0]         addr;
    logic                area;
    logic                rd_acked;
    logic                wrote;
    logic                wbusy;
    logic [WCNT_W-1:0]   wcnt;
    logic [7:0]          rxdata;
    logic                ctrl_mode;
    logic                ctrl_harv;
    logic [7:0]          txdata;
    logic                sda_o;
    logic                sda_oe;
    logic                rf_o;
    logic                rf_oe;
    logic                harvest_on;
    logic                avs_wait;
    logic [31:0]         avs_rdata;
  } tagfe_state_t;

endpackage : tagfe_pkg

// ---- core/tagfe_sync.sv ----
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module tagfe_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_q      <= '0;
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end

endmodule : tagfe_sync

// ---- verification/tagfe_i2c_master.sv ----
// Serial bus master model that clocks the tag front end
`timescale 1ns/1ps
module tagfe_i2c_master (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // Clock rests high between frames, data line released
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wt

  ////////////////////////////////////////////////////////////////////////////
  // One bit: data moves in the low phase, sampled mid high phase
  task automatic bit_x(input logic b, output logic s);
    o_scl <= 1'b0;
    wt(2);
    o_sda_oe <= ~b;
    wt(2);
    o_scl <= 1'b1;
    wt(2);
    s = i_sda;
    wt(2);
  endtask : bit_x

  task automatic start();
    if (i_sda !== 1'b1) begin
      o_scl <= 1'b0;
      wt(4);
      o_scl <= 1'b1;
      wt(4);
    end
    o_sda_oe <= 1'b1;
    wt(4);
  endtask : start

  task automatic stop();
    o_scl <= 1'b0;
    wt(2);
    o_sda_oe <= 1'b1;
    wt(2);
    o_scl <= 1'b1;
    wt(4);
    o_sda_oe <= 1'b0;
    wt(4);
  endtask : stop

  ////////////////////////////////////////////////////////////////////////////
  // Bytes go most significant bit first
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = (s === 1'b0);
  endtask : wbyte

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, s);
  endtask : rbyte
endmodule : tagfe_i2c_master

// ---- verification/test_tagfe_i2c_front_end.sv ----
// Testbench of the tag serial front end
`timescale 1ns/1ps
module test_tagfe_i2c_front_end;
  import tagfe_pkg::*;
  localparam logic [3:0]  DTYPE = 4'h5;  // Arbitrary value
  localparam int unsigned WCYC  = 300;
  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  tagfe_avs_req_t avs;
  tagfe_avs_rsp_t rsp;
  logic           scl, m_oe, d_o, d_oe, sda;
  logic           por, wb, cb, field, rf_o, rf_oe, harv, ack;
  logic [7:0]     rb;
  logic [31:0]    rd;
  int             err_total = 0;
  int             compares = 0;
  int             cyc = 0;

  assign sda = ~(m_oe | d_oe);
  always #4 clk = ~clk;

  tagfe_i2c_front_end #(.DEV_TYPE(DTYPE), .WRITE_CYCLES(WCYC)) i_tagfe_i2c_front_end (
    .i_clk(clk), .i_rst_n(rst_n), .i_avs(avs), .o_avs(rsp), .i_scl(scl), .i_sda_i(sda),
    .o_sda_o(d_o), .o_sda_oe(d_oe), .i_vcc_por_ok(por), .i_rf_write_busy(wb), .i_rf_cmd_busy(cb),
    .i_rf_field_ok(field), .o_rf_activity_out_o(rf_o), .o_rf_activity_out_oe(rf_oe), .o_harvest_on(harv));

  tagfe_i2c_master i_tagfe_i2c_master (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk);
    avs.read      <= ~wr;
    avs.write     <= wr;
    avs.address   <= a;
    avs.writedata <= wd;
    do begin
      @(posedge clk);
    end while (rsp.waitrequest !== 1'b0);
    r = rsp.readdata;
    avs.read  <= 1'b0;
    avs.write <= 1'b0;
  endtask : av

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    av(1'b0, a, 32'h0000_0000, r);
    chk(nm, exp, r);
  endtask : rdchk

  task automatic sel(input logic [3:0] t, input logic area, input logic rw, input logic exp);
    i_tagfe_i2c_master.start();
    i_tagfe_i2c_master.wbyte({t, area, DSEL_FIXED, rw}, ack);
    chk("select_ack", {31'h0, exp}, {31'h0, ack});
  endtask : sel

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    avs = '0;
    avs.byteenable = 4'h1;
    por = 1'b1;
    wb = 1'b0;
    cb = 1'b0;
    field = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("ctrl_rst", REG_CTRL, 32'h0000_0000);
    rdchk("tx_rst", REG_TXDATA, {24'h0, TXDATA_RST});
    rdchk("unmapped", 8'h14, 32'h0000_0000);
    av(1'b1, REG_STATUS, 32'h0000_00FF, rd);
    rdchk("status_idle", REG_STATUS, 32'h0000_0011);
    av(1'b1, REG_TXDATA, 32'h0000_003C, rd);
    rdchk("txdata", REG_TXDATA, 32'h0000_003C);
    // Write: select, address high then low, one data byte
    sel(DTYPE, 1'b0, 1'b0, 1'b1);
    chk("sda_o", 32'h0, {31'h0, d_o});
    i_tagfe_i2c_master.wbyte(8'h12, ack);
    chk("ahi_ack", 32'h1, {31'h0, ack});
    i_tagfe_i2c_master.wbyte(8'h34, ack);
    chk("alo_ack", 32'h1, {31'h0, ack});
    i_tagfe_i2c_master.wbyte(8'hA5, ack);
    chk("data_ack", 32'h1, {31'h0, ack});
    i_tagfe_i2c_master.stop();
    av(1'b0, REG_STATUS, 32'h0, rd);
    chk("wbusy_on", 32'h1, {31'h0, rd[STAT_WBUSY_BIT]});
    chk("standby_off", 32'h0, {31'h0, rd[STAT_STANDBY_BIT]});
    rdchk("addr", REG_ADDR, 32'h0000_1235);
    rdchk("rxdata", REG_RXDATA, 32'h0000_00A5);
    sel(DTYPE, 1'b0, 1'b0, 1'b0);
    i_tagfe_i2c_master.stop();
    repeat (WCYC) @(posedge clk);
    av(1'b0, REG_STATUS, 32'h0, rd);
    chk("standby", 32'h1, {31'h0, rd[STAT_STANDBY_BIT]});
    chk("wbusy_off", 32'h0, {31'h0, rd[STAT_WBUSY_BIT]});
    // Read with area bit set, master acks then refuses
    sel(DTYPE, 1'b1, 1'b1, 1'b1);
    i_tagfe_i2c_master.rbyte(1'b0, rb);
    chk("rbyte0", 32'h3C, {24'h0, rb});
    i_tagfe_i2c_master.rbyte(1'b1, rb);
    chk("rbyte1", 32'h3C, {24'h0, rb});
    i_tagfe_i2c_master.stop();
    av(1'b0, REG_STATUS, 32'h0, rd);
    chk("area", 32'h1, {31'h0, rd[STAT_AREA_BIT]});
    sel(~DTYPE, 1'b0, 1'b0, 1'b0);
    i_tagfe_i2c_master.stop();
    // Status pin modes and harvest output
    for (int k = 0; k < 16; k++) begin
      av(1'b1, REG_CTRL, {30'h0, k[0], k[3]}, rd);
      wb <= k[2];
      cb <= k[1];
      field <= k[1];
      repeat (6) @(posedge clk);
      chk("rf_oe", {31'h0, (k[3] ? k[1] : k[2])}, {31'h0, rf_oe});
      chk("rf_o", 32'h0, {31'h0, rf_o});
      chk("harvest", {31'h0, k[0] & k[1]}, {31'h0, harv});
    end
    // Power loss after standby was reached
    av(1'b1, REG_CTRL, 32'h0000_0000, rd);
    wb <= 1'b1;
    por <= 1'b0;
    repeat (6) @(posedge clk);
    chk("rf_oe_nopwr", 32'h0, {31'h0, rf_oe});
    sel(DTYPE, 1'b0, 1'b0, 1'b0);
    i_tagfe_i2c_master.stop();
    por <= 1'b1;
    repeat (8) @(posedge clk);
    av(1'b0, REG_STATUS, 32'h0, rd);
    chk("por_standby", 32'h1, {31'h0, rd[STAT_STANDBY_BIT]});
    chk("rf_oe_pwr", 32'h1, {31'h0, rf_oe});
    sel(DTYPE, 1'b0, 1'b0, 1'b1);
    i_tagfe_i2c_master.stop();
    print_verdict();
  end
endmodule : test_tagfe_i2c_front_end
